/* design/smsd_defs.svh */
// constants for the mode sense, start/stop and send diagnostic command block
// assumes inclusion by bare name from package and design modules
`ifndef SMSD_DEFS_SVH
`define SMSD_DEFS_SVH

// ==========================================================================
// opcodes and command descriptor byte positions
`define SMSD_OP_MODE_SENSE 8'h1A
`define SMSD_OP_START_STOP 8'h1B
`define SMSD_OP_SEND_DIAG 8'h1D
`define SMSD_CDB_OPCODE 0
`define SMSD_CDB_FLAGS 1
`define SMSD_CDB_PAGE 2
`define SMSD_CDB_PLEN_HI 3
`define SMSD_CDB_PLEN_LO 4
`define SMSD_CDB_ALLOC 4
`define SMSD_CDB_START 4

// ==========================================================================
// bit positions inside descriptor bytes
`define SMSD_BIT_EARLY 0
`define SMSD_BIT_START 0
`define SMSD_BIT_SELFTEST 2
`define SMSD_BIT_DEVICE_OFFLINE_BIT 1
`define SMSD_BIT_UNIT_OFFLINE_BIT 0
`define SMSD_BIT_SAVEABLE 7
`define SMSD_BIT_WP 7

// ==========================================================================
// mode sense data layout and values
`define SMSD_PAGE_GEOM 6'h04
`define SMSD_PAGE_ALL 6'h3F
`define SMSD_PCF_CHANGEABLE 2'h1
`define SMSD_LEN_FULL 6'h20
`define SMSD_LEN_SHORT 6'h0C
`define SMSD_IDX_LEN 5'h00
`define SMSD_IDX_WP 5'h02
`define SMSD_IDX_BDL 5'h03
`define SMSD_IDX_BLEN_HI 5'h09
`define SMSD_IDX_BLEN_MID 5'h0A
`define SMSD_IDX_BLEN_LO 5'h0B
`define SMSD_IDX_PG_CODE 5'h0C
`define SMSD_IDX_PG_LEN 5'h0D
`define SMSD_IDX_CYL_HI 5'h0E
`define SMSD_IDX_CYL_MID 5'h0F
`define SMSD_IDX_CYL_LO 5'h10
`define SMSD_IDX_HEADS 5'h11
`define SMSD_IDX_RWC_HI 5'h15
`define SMSD_IDX_RWC_MID 5'h16
`define SMSD_IDX_RWC_LO 5'h17
`define SMSD_IDX_STEP_HI 5'h18
`define SMSD_IDX_STEP_LO 5'h19
`define SMSD_BDL_VALUE 8'h08
`define SMSD_PG_LEN_VALUE 8'h12
`define SMSD_CYL_COUNT 24'h000342
`define SMSD_RWC_CYL 24'h00024E
`define SMSD_HEADS_SMALL 8'h03
`define SMSD_HEADS_LARGE 8'h06
`define SMSD_BLEN_CHANGEABLE 24'hFFFFFF

// ==========================================================================
// status and sense
`define SMSD_SK_NONE 4'h0
`define SMSD_SK_ILLEGAL 4'h5
`define SMSD_SK_HW_ERROR 4'h4
`define SMSD_ASC_NONE 8'h00
`define SMSD_ASC_INV_FIELD 8'h24

// ==========================================================================
// timing
`define SMSD_SPINUP_S 30
`define SMSD_CLK_HZ 20000000

`endif

/* design/smsd_pkg.sv */
// types shared by the command block and its mode data store
// assumes smsd_defs.svh on the include path
`include "smsd_defs.svh"

package smsd_pkg;

  typedef enum logic [2:0] {
    SMSD_IDLE, SMSD_MS_FETCH, SMSD_MS_SEND, SMSD_SS_WAIT,
    SMSD_DG_OUT, SMSD_DG_TEST
  } smsd_state_type;

  typedef struct packed {
    logic valid;
    logic [5:0][7:0] cdb;
  } smsd_cmd_type;

  typedef struct packed {
    logic valid;
    logic check;
    logic [3:0] sense_key;
    logic [7:0] sense_code;
  } smsd_status_type;

  typedef struct packed {
    logic spindle_en;
    logic actuator_en;
    logic unit_ready;
  } smsd_drive_type;

  typedef struct packed {
    logic changeable;
    logic heads_six;
    logic [5:0] total;
    logic [23:0] block_len;
    logic [15:0] step_rate;
  } smsd_page_cfg_type;

endpackage

/* design/smsd_mode_rom.sv */
// mode sense data store: header, block descriptor and geometry page
// assumes a single clock; read data is registered, one cycle after address
`timescale 1ns/100ps
`include "smsd_defs.svh"

module smsd_mode_rom (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire smsd_pkg::smsd_page_cfg_type cfg,
  output logic [7:0] rdata_q
);
  import smsd_pkg::*;

  logic [7:0] byte_d;
  logic [23:0] blen;
  logic pg;

  // ========================================================================
  // byte select
  always_comb begin
    blen = cfg.changeable ? `SMSD_BLEN_CHANGEABLE : cfg.block_len;
    // nothing in the geometry page is initiator changeable
    pg = !cfg.changeable;
    unique case (addr)
      `SMSD_IDX_LEN: byte_d = {2'h0, cfg.total - 6'h01}; // R1
      `SMSD_IDX_WP: byte_d = 8'h00; // R2
      `SMSD_IDX_BDL: byte_d = `SMSD_BDL_VALUE; // R3
      `SMSD_IDX_BLEN_HI: byte_d = blen[23:16]; // R4
      `SMSD_IDX_BLEN_MID: byte_d = blen[15:8]; // R4
      `SMSD_IDX_BLEN_LO: byte_d = blen[7:0]; // R4
      // geometry page is fixed, so not saveable
      `SMSD_IDX_PG_CODE: byte_d = {2'h0, `SMSD_PAGE_GEOM}; // R5 R6
      `SMSD_IDX_PG_LEN: byte_d = `SMSD_PG_LEN_VALUE; // R6
      `SMSD_IDX_CYL_HI: byte_d = pg ? 8'(`SMSD_CYL_COUNT >> 16) : 8'h00; // R7
      `SMSD_IDX_CYL_MID: byte_d = pg ? 8'(`SMSD_CYL_COUNT >> 8) : 8'h00; // R7
      `SMSD_IDX_CYL_LO: byte_d = pg ? 8'(`SMSD_CYL_COUNT) : 8'h00; // R7
      `SMSD_IDX_HEADS: byte_d = !pg ? 8'h00 : cfg.heads_six ? `SMSD_HEADS_LARGE : `SMSD_HEADS_SMALL; // R7
      `SMSD_IDX_RWC_HI: byte_d = pg ? 8'(`SMSD_RWC_CYL >> 16) : 8'h00; // R8
      `SMSD_IDX_RWC_MID: byte_d = pg ? 8'(`SMSD_RWC_CYL >> 8) : 8'h00; // R8
      `SMSD_IDX_RWC_LO: byte_d = pg ? 8'(`SMSD_RWC_CYL) : 8'h00; // R8
      `SMSD_IDX_STEP_HI: byte_d = pg ? cfg.step_rate[15:8] : 8'h00; // R8
      `SMSD_IDX_STEP_LO: byte_d = pg ? cfg.step_rate[7:0] : 8'h00; // R8
      // density, block count, precomp, landing zone, reserved are zero
      default: byte_d = 8'h00; // R4 R8 R9 R21
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= byte_d;
    end
  end

endmodule // smsd_mode_rom

/* design/smsd_cmd_top.sv */
// command block for mode sense, start/stop unit and send diagnostic
// assumes a bus phase engine that delivers the cdb, moves data bytes and
// returns status; the self test engine and spindle servo sit outside
//
// Functional notes
// R1: mode data byte 0 counts the bytes that follow it
// R2: write-protect bit of header byte 2 always reads zero
// R3: header byte 3 reports a block descriptor length of eight
// R4: descriptor: density 0, block count 0, reserved 0, block length bytes 5-7
// R5: page header bit 7 flags saveable pages; changeable pages are saveable
// R6: geometry page code 04h, length 12h, top two bits zero
// R7: cylinders 834 as three bytes; head count 3 or 6 by variant
// R8: precomp 0, reduced write current 00024Eh, step rate, landing zone 0
// R9: heads park by themselves at power loss; no landing seek needed
// R10: start/stop starts drive on start bit one, stops on zero
// R11: early status bit returns status at start, else after completion
// R12: start or stop matching present state completes with no change
// R13: no jumper spins up alone; jumper fitted waits for start command
// R14: disk access waits for spin-up up to 30 s; stopped disables motors
// R15: self test runs; good status on pass, hardware error check on fail
// R16: initiator sets list length zero for the default self test
// R17: device offline bit set gives illegal request, invalid field
// R18: unit offline bit set gives illegal request, invalid field
// R19: list length sets data-out byte count; zero is no transfer, no error
// R20: data-in stops at allocation length or available data, the lesser
// R21: changeable values show ones in changeable fields, zeros elsewhere
// R22: received diagnostic parameter bytes are accepted and discarded
`timescale 1ns/100ps
`include "smsd_defs.svh"

module smsd_cmd_top #(
  parameter int unsigned SPINUP_CYCLES = `SMSD_SPINUP_S * `SMSD_CLK_HZ
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire smsd_pkg::smsd_cmd_type CMD,
  output logic CMD_READY,
  output logic [7:0] DIN_BYTE,
  output logic DIN_VALID,
  input wire logic DIN_READY,
  input wire logic [7:0] DOUT_BYTE,
  input wire logic DOUT_VALID,
  output logic DOUT_READY,
  output smsd_pkg::smsd_status_type STATUS,
  input wire logic AUTOSTART_JUMPER,
  input wire logic HEADS_SIX,
  input wire logic [23:0] BLOCK_LEN,
  input wire logic [15:0] STEP_RATE,
  output logic SELFTEST_GO,
  input wire logic SELFTEST_DONE,
  input wire logic SELFTEST_PASS,
  output smsd_pkg::smsd_drive_type DRIVE
);
  import smsd_pkg::*;

  // ========================================================================
  // state
  typedef struct packed {
    smsd_state_type st;
    logic [5:0] idx;
    logic [5:0] cnt;
    logic [5:0] total;
    logic chg;
    logic [15:0] plen;
    logic self_test;
    logic spin_on;
    logic ready;
    logic [29:0] spin_cnt;
    logic booted;
    logic go;
    smsd_status_type stat;
  } smsd_regs_type;

  smsd_regs_type r_q, r_d;
  logic take;
  logic [7:0] op, flags, pgb, alloc;
  logic [5:0] alloc6;
  logic page_ok;
  logic [7:0] rom_q;
  smsd_page_cfg_type cfg;

  function automatic smsd_status_type mk_stat(input logic chk, input logic [3:0] key, input logic [7:0] asc);
    mk_stat = '{valid: 1'b1, check: chk, sense_key: key, sense_code: asc};
  endfunction

  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    min6 = (a < b) ? a : b;
  endfunction

  assign take = CMD.valid && (r_q.st == SMSD_IDLE);
  assign op = CMD.cdb[`SMSD_CDB_OPCODE];
  assign flags = CMD.cdb[`SMSD_CDB_FLAGS];
  assign pgb = CMD.cdb[`SMSD_CDB_PAGE];
  assign alloc = CMD.cdb[`SMSD_CDB_ALLOC];
  // allocations beyond the full data length act as the full length
  assign alloc6 = (alloc > 8'(`SMSD_LEN_FULL)) ? `SMSD_LEN_FULL : alloc[5:0];
  assign page_ok = (pgb[5:0] == `SMSD_PAGE_GEOM) || (pgb[5:0] == `SMSD_PAGE_ALL);

  // ========================================================================
  // mode data store
  assign cfg = '{changeable: r_q.chg, heads_six: HEADS_SIX, total: r_q.total,
                 block_len: BLOCK_LEN, step_rate: STEP_RATE};

  smsd_mode_rom u_rom (
    .clk(CLK_SYS),
    .rst(RST),
    .addr(r_q.idx[4:0]),
    .cfg(cfg),
    .rdata_q(rom_q)
  );

  // ========================================================================
  // next state
  always_comb begin
    r_d = r_q;
    r_d.go = 1'b0;
    r_d.stat.valid = 1'b0;
    // spindle: catch the jumper once, on the first edge after reset release
    if (!r_q.booted) begin
      r_d.booted = 1'b1;
      r_d.spin_on = !AUTOSTART_JUMPER; // R13
    end
    if (!r_q.spin_on) begin
      r_d.ready = 1'b0; // R14
      r_d.spin_cnt = '0;
    end else if (!r_q.ready) begin
      if (r_q.spin_cnt == 30'(SPINUP_CYCLES - 1)) begin
        r_d.ready = 1'b1; // R14
      end else begin
        r_d.spin_cnt = r_q.spin_cnt + 30'h00000001;
      end
    end
    unique case (r_q.st)
      SMSD_IDLE: begin
        if (take) begin
          if (op == `SMSD_OP_MODE_SENSE) begin
            r_d.chg = (pgb[7:6] == `SMSD_PCF_CHANGEABLE); // R21
            r_d.idx = '0;
            if (page_ok) begin
              r_d.total = `SMSD_LEN_FULL;
            end else begin
              r_d.total = `SMSD_LEN_SHORT;
            end
            // unsupported pages see header and descriptor only
            if (!page_ok && alloc > 8'(`SMSD_LEN_SHORT)) begin
              r_d.stat = mk_stat(1'b1, `SMSD_SK_ILLEGAL, `SMSD_ASC_INV_FIELD);
            end else if (alloc == 8'h00) begin
              r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE);
            end else begin
              r_d.cnt = min6(alloc6, page_ok ? `SMSD_LEN_FULL : `SMSD_LEN_SHORT); // R20
              r_d.st = SMSD_MS_FETCH;
            end
          end else if (op == `SMSD_OP_START_STOP) begin
            if (CMD.cdb[`SMSD_CDB_START][`SMSD_BIT_START]) begin
              r_d.spin_on = 1'b1; // R10 R12
              // early status, or already up to speed
              if (flags[`SMSD_BIT_EARLY] || r_q.ready) begin
                r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE); // R11 R12
              end else begin
                r_d.st = SMSD_SS_WAIT; // R11
              end
            end else begin
              // stop completes at once: motor and actuator simply drop
              r_d.spin_on = 1'b0; // R10 R12 R14
              // ready drops with the motor, never a cycle later
              r_d.ready = 1'b0; // R14
              r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE); // R11
            end
          end else if (op == `SMSD_OP_SEND_DIAG) begin
            r_d.plen = {CMD.cdb[`SMSD_CDB_PLEN_HI], CMD.cdb[`SMSD_CDB_PLEN_LO]}; // R19
            r_d.self_test = flags[`SMSD_BIT_SELFTEST];
            if (flags[`SMSD_BIT_DEVICE_OFFLINE_BIT] || flags[`SMSD_BIT_UNIT_OFFLINE_BIT]) begin
              r_d.stat = mk_stat(1'b1, `SMSD_SK_ILLEGAL, `SMSD_ASC_INV_FIELD); // R17 R18
            end else if ({CMD.cdb[`SMSD_CDB_PLEN_HI], CMD.cdb[`SMSD_CDB_PLEN_LO]} != 16'h0000) begin
              r_d.st = SMSD_DG_OUT; // R19 R22
            end else if (flags[`SMSD_BIT_SELFTEST]) begin
              r_d.go = 1'b1; // R15
              r_d.st = SMSD_DG_TEST;
            end else begin
              r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE); // R19
            end
          end
        end
      end
      SMSD_MS_FETCH: begin
        r_d.st = SMSD_MS_SEND;
      end
      SMSD_MS_SEND: begin
        if (DIN_READY) begin
          if (r_q.idx + 6'h01 == r_q.cnt) begin
            r_d.st = SMSD_IDLE; // R20
            r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE);
          end else begin
            r_d.idx = r_q.idx + 6'h01;
            r_d.st = SMSD_MS_FETCH;
          end
        end
      end
      SMSD_SS_WAIT: begin
        if (!r_q.spin_on || r_q.ready) begin
          r_d.st = SMSD_IDLE; // R11
          r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE);
        end
      end
      SMSD_DG_OUT: begin
        // bytes are taken and dropped; the list has no defined meaning
        if (DOUT_VALID) begin
          r_d.plen = r_q.plen - 16'h0001; // R22
          if (r_q.plen == 16'h0001) begin
            if (r_q.self_test) begin
              r_d.go = 1'b1; // R15
              r_d.st = SMSD_DG_TEST;
            end else begin
              r_d.st = SMSD_IDLE;
              r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE);
            end
          end
        end
      end
      SMSD_DG_TEST: begin
        if (SELFTEST_DONE) begin
          r_d.st = SMSD_IDLE;
          if (SELFTEST_PASS) begin
            r_d.stat = mk_stat(1'b0, `SMSD_SK_NONE, `SMSD_ASC_NONE); // R15
          end else begin
            r_d.stat = mk_stat(1'b1, `SMSD_SK_HW_ERROR, `SMSD_ASC_NONE); // R15
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      r_q <= '{st: SMSD_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ========================================================================
  // outputs
  assign CMD_READY = (r_q.st == SMSD_IDLE);
  assign DIN_VALID = (r_q.st == SMSD_MS_SEND);
  assign DIN_BYTE = rom_q;
  assign DOUT_READY = (r_q.st == SMSD_DG_OUT);
  assign STATUS = r_q.stat;
  assign SELFTEST_GO = r_q.go;
  // heads park on their own at power loss, so no landing seek on stop
  assign DRIVE = '{spindle_en: r_q.spin_on, actuator_en: r_q.spin_on, unit_ready: r_q.ready}; // R9 R14

  // ========================================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence ss_take(bit start, bit early);
    take && op == `SMSD_OP_START_STOP && CMD.cdb[`SMSD_CDB_START][`SMSD_BIT_START] == start
      && flags[`SMSD_BIT_EARLY] == early;
  endsequence

  sequence dg_offline;
    take && op == `SMSD_OP_SEND_DIAG && (flags[`SMSD_BIT_DEVICE_OFFLINE_BIT] || flags[`SMSD_BIT_UNIT_OFFLINE_BIT]);
  endsequence

  len_byte_a: assert property (DIN_VALID && r_q.idx == 6'h00 |-> DIN_BYTE == {2'h0, r_q.total - 6'h01}) // R1
    else $error("mode data length byte wrong");
  wp_zero_a: assert property (DIN_VALID && r_q.idx == 6'h02 |-> !DIN_BYTE[`SMSD_BIT_WP]) // R2
    else $error("write protect bit set");
  bdl_eight_a: assert property (DIN_VALID && r_q.idx == 6'h03 |-> DIN_BYTE == 8'h08) // R3
    else $error("block descriptor length not eight");
  desc_zero_a: assert property (DIN_VALID && r_q.idx inside {[6'h04:6'h08]} |-> DIN_BYTE == 8'h00) // R4
    else $error("descriptor zero field not zero");
  page_head_a: assert property (DIN_VALID && r_q.idx == 6'h0C |=> $past(DIN_BYTE) == 8'h04) // R5 R6
    else $error("geometry page code byte wrong");
  cyl_count_a: assert property (DIN_VALID && r_q.idx == 6'h10 && !r_q.chg |-> DIN_BYTE == 8'h42) // R7
    else $error("cylinder low byte wrong");
  rwc_cyl_a: assert property (DIN_VALID && r_q.idx == 6'h17 && !r_q.chg |-> DIN_BYTE == 8'h4E) // R8
    else $error("reduced write current low byte wrong");
  chg_zero_a: assert property (DIN_VALID && r_q.chg && r_q.idx > 6'h0D |-> DIN_BYTE == 8'h00) // R21
    else $error("changeable page field not zero");
  alloc_cap_a: assert property (DIN_VALID |-> r_q.idx < r_q.cnt && r_q.cnt <= r_q.total) // R20
    else $error("data-in runs past allowed count");
  early_stat_a: assert property (ss_take(1'b1, 1'b1) |=> STATUS.valid && !STATUS.check) // R11
    else $error("early status not returned at once");
  late_stat_a: assert property (ss_take(1'b1, 1'b0) ##0 !r_q.ready |=> !STATUS.valid) // R11
    else $error("status returned before spin-up");
  stop_off_a: assert property (ss_take(1'b0, 1'b0) |=> !DRIVE.spindle_en && !DRIVE.actuator_en) // R10 R14
    else $error("stop left motors enabled");
  ready_wait_a: assert property ($rose(DRIVE.unit_ready) |-> $past(r_q.spin_cnt) == 30'(SPINUP_CYCLES - 1)) // R14
    else $error("ready before spin-up time");
  autostart_a: assert property (!r_q.booted && !AUTOSTART_JUMPER |=> DRIVE.spindle_en) // R13
    else $error("no spin-up without jumper");
  offline_a: assert property (dg_offline |=> STATUS.valid && STATUS.check
      && STATUS.sense_key == 4'h5 && STATUS.sense_code == 8'h24) // R17 R18
    else $error("offline bit not rejected");
  test_fail_a: assert property (r_q.st == SMSD_DG_TEST && SELFTEST_DONE && !SELFTEST_PASS
      |=> STATUS.valid && STATUS.check && STATUS.sense_key == 4'h4) // R15
    else $error("failed self test not reported");
  zero_list_a: assert property (take && op == `SMSD_OP_SEND_DIAG && !flags[2] && flags[1:0] == 2'h0
      && {CMD.cdb[3], CMD.cdb[4]} == 16'h0000 |=> STATUS.valid && !STATUS.check) // R19
    else $error("zero list length not good status");

  // handshake, page bytes, pulse, status and drive state
  din_hold_a: assert property (DIN_VALID && !DIN_READY // R20
      |=> DIN_VALID && $stable(DIN_BYTE))
    else $error("held data-in byte changed");

  page_len_a: assert property (DIN_VALID && r_q.idx == 6'h0D // R6
      |-> DIN_BYTE == 8'h12)
    else $error("geometry page length wrong");

  head_count_a: assert property (DIN_VALID && r_q.idx == 6'h11 && !r_q.chg // R7
      |-> DIN_BYTE == (HEADS_SIX ? 8'h06 : 8'h03))
    else $error("head count byte wrong");

  // the test engine sees exactly one start pulse
  go_pulse_a: assert property (SELFTEST_GO // R15
      |-> r_q.st == SMSD_DG_TEST ##1 !SELFTEST_GO)
    else $error("self test start not a single pulse");

  test_pass_a: assert property (r_q.st == SMSD_DG_TEST && SELFTEST_DONE && SELFTEST_PASS // R15
      |=> STATUS.valid && !STATUS.check)
    else $error("passed self test not good status");

  list_end_a: assert property (r_q.st == SMSD_DG_OUT && DOUT_VALID && r_q.plen == 16'h0001 && !r_q.self_test // R19 R22
      |=> STATUS.valid && !STATUS.check)
    else $error("list end not good status");

  // a stopped drive must never claim disk access
  stop_ready_a: assert property (!DRIVE.spindle_en // R14
      |-> !DRIVE.unit_ready)
    else $error("ready while spindle off");

  start_again_a: assert property (take && op == `SMSD_OP_START_STOP && CMD.cdb[`SMSD_CDB_START][`SMSD_BIT_START] && r_q.ready // R12
      |=> STATUS.valid && DRIVE.unit_ready)
    else $error("repeated start disturbed drive");

  bad_page_a: assert property (take && op == `SMSD_OP_MODE_SENSE && !page_ok && alloc > 8'h0C // R20
      |=> STATUS.valid && STATUS.check && STATUS.sense_key == 4'h5)
    else $error("illegal page not rejected");

  alloc_zero_a: assert property (take && op == `SMSD_OP_MODE_SENSE && page_ok && alloc == 8'h00 // R20
      |=> STATUS.valid && !STATUS.check && !DIN_VALID)
    else $error("zero allocation not good status");

endmodule // smsd_cmd_top

/* verification/smsd_init_model.sv */
// initiator model: sinks data-in bytes, sources data-out list bytes
// assumes one clock; testbench loads out_left and reads rx, rx_n, out_n
`timescale 1ns/100ps

module smsd_init_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic din_valid,
  input wire logic [7:0] din_byte,
  output logic din_ready,
  output logic dout_valid,
  output logic [7:0] dout_byte,
  input wire logic dout_ready
);
  logic [7:0] rx [0:31];
  int rx_n = 0;
  int out_left = 0;
  int out_n = 0;
  logic ph = 1'b0;

  initial begin
    din_ready = 1'b1;
    dout_valid = 1'b0;
    dout_byte = 8'hA5;
  end

  // ==========================================================================
  // data-in sink; stall halves the accept rate
  always @(posedge clk) begin
    if (din_valid && din_ready) begin
      if (rx_n < 32) rx[rx_n] = din_byte;
      rx_n++;
    end
    #2;
    ph = ~ph;
    din_ready = ~stall | ph;
  end

  // ==========================================================================
  // data-out source: exactly the list length, zero means nothing sent
  always @(posedge clk) begin
    if (dout_valid && dout_ready) begin
      out_left--;
      out_n++;
    end
    #2;
    dout_valid = out_left > 0;
    // released line toggles so a stale byte is never mistaken for data
    dout_byte = dout_valid ? 8'h30 + out_n[7:0] : ~dout_byte;
  end
endmodule // smsd_init_model

/* verification/testbench.sv */
// self-checking bench for the mode sense, start/stop, diagnostic block
// assumes smsd_pkg compiled first; spin-up shortened to 20 cycles
`timescale 1ns/100ps

module testbench;
  import smsd_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  smsd_cmd_type CMD = '0;
  logic CMD_READY, DIN_VALID, DIN_READY, DOUT_VALID, DOUT_READY, SELFTEST_GO;
  logic [7:0] DIN_BYTE, DOUT_BYTE;
  smsd_status_type STATUS, st;
  smsd_drive_type DRIVE;
  logic AUTOSTART_JUMPER = 1'b1;
  logic HEADS_SIX = 1'b1;
  logic [23:0] BLOCK_LEN = 24'h000200;
  logic [15:0] STEP_RATE = 16'h0A05;
  logic SELFTEST_DONE = 1'b0;
  logic SELFTEST_PASS = 1'b0;
  logic stall = 1'b0;
  logic st_pass = 1'b1;
  int fails = 0;
  int check_count = 0;
  int lat;

  smsd_cmd_top #(.SPINUP_CYCLES(20)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .CMD(CMD), .CMD_READY(CMD_READY),
    .DIN_BYTE(DIN_BYTE), .DIN_VALID(DIN_VALID), .DIN_READY(DIN_READY), .DOUT_BYTE(DOUT_BYTE),
    .DOUT_VALID(DOUT_VALID), .DOUT_READY(DOUT_READY), .STATUS(STATUS), .AUTOSTART_JUMPER(AUTOSTART_JUMPER),
    .HEADS_SIX(HEADS_SIX), .BLOCK_LEN(BLOCK_LEN), .STEP_RATE(STEP_RATE), .SELFTEST_GO(SELFTEST_GO),
    .SELFTEST_DONE(SELFTEST_DONE), .SELFTEST_PASS(SELFTEST_PASS), .DRIVE(DRIVE));

  smsd_init_model init (.clk(CLK_SYS), .stall(stall), .din_valid(DIN_VALID), .din_byte(DIN_BYTE),
    .din_ready(DIN_READY), .dout_valid(DOUT_VALID), .dout_byte(DOUT_BYTE), .dout_ready(DOUT_READY));

  // ==========================================================================
  // clock, watchdog, self test engine stand-in
  initial begin
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    #(50 * 5000);
    fails++;
    print_verdict();
  end

  always @(posedge CLK_SYS) begin
    if (SELFTEST_GO) begin
      repeat (3) @(posedge CLK_SYS);
      #2;
      SELFTEST_DONE = 1'b1;
      SELFTEST_PASS = st_pass;
      @(posedge CLK_SYS);
      #2;
      SELFTEST_DONE = 1'b0;
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_status(input logic chk, input logic [3:0] key, input logic [7:0] code);
    check_val("status", {1'b1, chk, key, code}, {st.valid, st.check, st.sense_key, st.sense_code});
  endtask

  task automatic do_reset(input logic jumper);
    RST = 1'b1;
    AUTOSTART_JUMPER = jumper;
    repeat (8) @(posedge CLK_SYS);
    #2;
    RST = 1'b0;
  endtask

  // offers one command, then waits for its status; lat counts cycles
  task automatic issue(input logic [7:0] op, b1, b2, b3, b4);
    CMD.cdb = {8'h00, b4, b3, b2, b1, op};
    CMD.valid = 1'b1;
    lat = 0;
    while (CMD_READY !== 1'b1 && lat < 100) begin
      @(posedge CLK_SYS);
      #2;
      lat++;
    end
    @(posedge CLK_SYS);
    #2;
    CMD.valid = 1'b0;
    st = '0;
    // status may stand in the cycle right after the take edge
    lat = 1;
    while (lat < 400 && st.valid !== 1'b1) begin
      if (STATUS.valid === 1'b1) begin
        st = STATUS;
      end else begin
        @(posedge CLK_SYS);
        #2;
        lat++;
      end
    end
  endtask

  function automatic logic [7:0] exp_byte(int i, logic ch);
    logic [7:0] g [0:31];
    g = '{default: 8'h00};
    g[0] = 8'h1F;
    g[3] = 8'h08;
    {g[9], g[10], g[11]} = ch ? 24'hFFFFFF : BLOCK_LEN;
    g[12] = 8'h04;
    g[13] = 8'h12;
    if (!ch) begin
      {g[14], g[15], g[16]} = 24'd834;
      g[17] = HEADS_SIX ? 8'h06 : 8'h03;
      {g[21], g[22], g[23]} = 24'h00024E;
      {g[24], g[25]} = STEP_RATE;
    end
    return g[i];
  endfunction

  task automatic mode_sense(input logic [7:0] b2, input logic [7:0] alloc, input int n, input logic [7:0] b0);
    init.rx_n = 0;
    issue(8'h1A, 8'h00, b2, 8'h00, alloc);
    check_status(1'b0, 4'h0, 8'h00);
    check_val("byte count", n, init.rx_n);
    for (int i = 0; i < n; i++) begin
      check_val("mode byte", i == 0 ? b0 : exp_byte(i, b2[6]), init.rx[i]);
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic spin_tests();
    do_reset(1'b1);
    repeat (30) @(posedge CLK_SYS);
    #2;
    check_val("idle spindle", 1'b0, DRIVE.spindle_en);
    issue(8'h1B, 8'h00, 8'h00, 8'h00, 8'h01);
    check_status(1'b0, 4'h0, 8'h00);
    check_val("waited spin-up", 1'b1, lat >= 20 && DRIVE.unit_ready === 1'b1);
    issue(8'h1B, 8'h01, 8'h00, 8'h00, 8'h01);
    check_val("repeat start", {1'b1, 8'd1}, {st.valid & ~st.check, lat[7:0]});
    issue(8'h1B, 8'h01, 8'h00, 8'h00, 8'h00);
    check_val("stop", {1'b1, 8'd1, 3'b000}, {st.valid & ~st.check, lat[7:0], DRIVE});
    issue(8'h1B, 8'h00, 8'h00, 8'h00, 8'h00);
    check_val("repeat stop", {1'b1, 3'b000}, {st.valid & ~st.check, DRIVE});
    issue(8'h1B, 8'h01, 8'h00, 8'h00, 8'h01);
    check_val("early start", {8'd1, 3'b110}, {lat[7:0], DRIVE});
    repeat (25) @(posedge CLK_SYS);
    #2;
    check_val("spun up", 3'b111, DRIVE);
  endtask

  task automatic sense_tests();
    stall = 1'b1;
    mode_sense(8'h04, 8'hFF, 32, 8'h1F);
    HEADS_SIX = 1'b0;
    BLOCK_LEN = 24'h000400;
    mode_sense(8'h3F, 8'h05, 5, 8'h1F);
    mode_sense(8'h7F, 8'h20, 32, 8'h1F);
    stall = 1'b0;
    mode_sense(8'h05, 8'h0C, 12, 8'h0B);
    mode_sense(8'h04, 8'h00, 0, 8'h1F);
    init.rx_n = 0;
    issue(8'h1A, 8'h00, 8'h05, 8'h00, 8'h0D);
    check_status(1'b1, 4'h5, 8'h24);
    check_val("rejected bytes", 0, init.rx_n);
  endtask

  task automatic diag_tests();
    issue(8'h1D, 8'h02, 8'h00, 8'h00, 8'h00);
    check_status(1'b1, 4'h5, 8'h24);
    issue(8'h1D, 8'h01, 8'h00, 8'h00, 8'h00);
    check_status(1'b1, 4'h5, 8'h24);
    issue(8'h1D, 8'h04, 8'h00, 8'h00, 8'h00);
    check_status(1'b0, 4'h0, 8'h00);
    check_val("test ran", 1'b1, lat > 3);
    st_pass = 1'b0;
    issue(8'h1D, 8'h04, 8'h00, 8'h00, 8'h00);
    check_status(1'b1, 4'h4, 8'h00);
    init.out_n = 0;
    init.out_left = 3;
    issue(8'h1D, 8'h00, 8'h00, 8'h00, 8'h03);
    check_status(1'b0, 4'h0, 8'h00);
    check_val("list taken", 3, init.out_n);
    issue(8'h1D, 8'h00, 8'h00, 8'h00, 8'h00);
    check_val("empty list", {1'b1, 8'd1}, {st.valid & ~st.check, lat[7:0]});
  endtask

  task automatic autostart_test();
    do_reset(1'b0);
    repeat (3) @(posedge CLK_SYS);
    #2;
    check_val("self start", 1'b1, DRIVE.spindle_en);
    repeat (25) @(posedge CLK_SYS);
    #2;
    check_val("self ready", 1'b1, DRIVE.unit_ready);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    spin_tests();
    sense_tests();
    diag_tests();
    autostart_test();
    print_verdict();
  end
endmodule // testbench
